/* File: rtl/pmrc_pkg.sv */
// Constants and carrier types for the power-mode and reset control unit.
// Assumes a single 250 MHz clock standing in for the oscillator.
package pmrc_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] PMRC_PCTL_ADDR      = 8'h87;
  localparam logic [7:0] PMRC_PCTL_RESET     = 8'h00;
  localparam logic [7:0] PMRC_PCTL_WMASK     = 8'hbf;
  localparam int         PMRC_BIT_IDLE       = 0;
  localparam int         PMRC_BIT_PDOWN      = 1;
  localparam int         PMRC_BIT_FLAG0      = 2;
  localparam int         PMRC_BIT_FLAG1      = 3;
  localparam int         PMRC_BIT_WLOAD      = 4;
  localparam int         PMRC_BIT_QUIET      = 5;
  localparam int         PMRC_BIT_RSVD       = 6;
  localparam int         PMRC_BIT_BAUD2      = 7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         PMRC_OSC_PER_MC     = 12;
  localparam int         PMRC_CLK_PER_MC     = PMRC_OSC_PER_MC;
  localparam logic [3:0] PMRC_MC_LAST        = 4'(PMRC_CLK_PER_MC - 1);
  localparam logic [1:0] PMRC_RST_HIGH_MC    = 2'h2;
  localparam logic [1:0] PMRC_WDOG_PULSE_MC  = 2'h3;

  // Operating modes
  typedef enum logic [1:0]
  {
    PMRC_RUN   = 2'b00,
    PMRC_IDLE  = 2'b01,
    PMRC_PDOWN = 2'b10,
    PMRC_RESET = 2'b11
  } pmrc_mode_type;

  // Register bus request from the CPU core
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmrc_sfr_req_type;

  // Controls broadcast to the peripherals
  typedef struct packed
  {
    logic cpu_halt;
    logic osc_stop;
    logic capture_timer_clear;
    logic pulse_out_reset;
    logic adc_abort;
    logic baud_doubler_bit;
    logic watchdog_run;
  } pmrc_periph_ctl_type;

endpackage : pmrc_pkg

/* File: rtl/pmrc_mc_timer.sv */
// Machine-cycle divider for the power-mode and reset control unit.
// Assumes clk is the oscillator; emits one enable per twelve clocks.
`timescale 1ns/100ps
module pmrc_mc_timer
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      mc_tick
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // Count stays frozen while the oscillator is stopped
  always_comb
  begin
    cnt_d = cnt_q;
    if (run)
    begin
      cnt_d = (cnt_q == pmrc_pkg::PMRC_MC_LAST) ? 4'h0 : 4'(cnt_q + 4'h1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  end

  // Tick on the last clock of each machine cycle
  assign mc_tick = run && (cnt_q == pmrc_pkg::PMRC_MC_LAST);

endmodule : pmrc_mc_timer

/* File: rtl/pmrc_ctrl.sv */
// Power-mode and reset control: power control register, idle and
// power-down sequencing, reset pin sampling and watchdog reset pulse.
// Assumes the CPU core presents whole-byte register accesses and that
// the watchdog counter reports its own load and overflow events.
`timescale 1ns/100ps
module pmrc_ctrl
(
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire pmrc_pkg::pmrc_sfr_req_type    sfr_req,
  output logic [7:0]                         sfr_rdata,
  input  wire logic                          irq_pending,
  input  wire logic                          watchdog_enable_n_pin,
  input  wire logic                          watchdog_counter_load,
  input  wire logic                          watchdog_counter_ovf,
  input  wire logic                          ext_prog_mem,
  input  wire logic                          rst_pin_in,
  output logic                               rst_pin_out,
  output logic                               rst_pin_oe,
  output logic                               core_reset,
  input  wire logic                          ale_core,
  input  wire logic                          program_store_strobe_core,
  output logic                               ale_out,
  output logic                               program_store_strobe,
  output logic                               port_two_restore,
  output logic                               port0_float,
  output logic                               pulse_out_zero_force,
  output pmrc_pkg::pmrc_periph_ctl_type      periph_ctl,
  output pmrc_pkg::pmrc_mode_type            mode
);

  // ****************************************
  // Register decode
  // ****************************************

  // The register is byte-wide only: there is no bit-set path, so a
  // read-modify-write in the core is the only way to touch one field.
  // Accesses to any other address are passed over without an answer.

  // One address decode shared by reads and writes
  function automatic logic hit_pctl(input logic [7:0] a);
    hit_pctl = (a == pmrc_pkg::PMRC_PCTL_ADDR);
  endfunction : hit_pctl

  logic wr_hit;
  logic rd_hit;
  logic mc_tick;
  logic osc_run;

  assign wr_hit = sfr_req.wr && hit_pctl(sfr_req.addr);
  assign rd_hit = sfr_req.rd && hit_pctl(sfr_req.addr);

  // ****************************************
  // Machine-cycle enable
  // ****************************************
  pmrc_mc_timer u_mc
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (osc_run),
    .mc_tick (mc_tick)
  );

  // ****************************************
  // Reset pin sampling and watchdog pulse
  // ****************************************
  logic       rst_smp_q;
  logic       rst_smp_d;
  logic [1:0] rst_hi_q;
  logic [1:0] rst_hi_d;
  logic [1:0] wd_cnt_q;
  logic [1:0] wd_cnt_d;
  logic       int_rst;

  // The pin is looked at only on the machine-cycle tick, so a glitch
  // between ticks cannot start a reset. The high-cycle count saturates
  // at two, which keeps the internal reset asserted without a break for as
  // long as the pin stays high, and drops to zero on any low sample.
  // The watchdog pulse counter is loaded on overflow at once, not on a
  // tick, so the pulse length is two whole cycles
  // plus the part cycle up to the first tick.

  // Pin seen once per machine cycle; count consecutive high cycles
  always_comb
  begin
    rst_smp_d = rst_smp_q;
    rst_hi_d  = rst_hi_q;
    wd_cnt_d  = wd_cnt_q;
    if (mc_tick)
    begin
      rst_smp_d = rst_pin_in;
      if (!rst_pin_in)
        rst_hi_d = 2'h0;
      else if (rst_hi_q != pmrc_pkg::PMRC_RST_HIGH_MC)
        rst_hi_d = 2'(rst_hi_q + 2'h1);
      if (wd_cnt_q != 2'h0)
        wd_cnt_d = 2'(wd_cnt_q - 2'h1);
    end
    // Overflow only counts while the watchdog is enabled
    if (watchdog_counter_ovf && !watchdog_enable_n_pin)
      wd_cnt_d = pmrc_pkg::PMRC_WDOG_PULSE_MC;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_smp_q <= 1'b0;
      rst_hi_q  <= 2'h0;
      wd_cnt_q  <= 2'h0;
    end
    else
    begin
      rst_smp_q <= rst_smp_d;
      rst_hi_q  <= rst_hi_d;
      wd_cnt_q  <= wd_cnt_d;
    end
  end

  // Internal reset from second high cycle, or forced by the watchdog
  // even if the pin is held low externally
  assign int_rst     = (rst_hi_q == pmrc_pkg::PMRC_RST_HIGH_MC)
                       || (wd_cnt_q != 2'h0);
  assign rst_pin_out = 1'b1;
  assign rst_pin_oe  = (wd_cnt_q != 2'h0);
  // Only control state is cleared; RAM sits outside this reset
  assign core_reset  = sys_rst || int_rst;

  // ****************************************
  // Power control register and mode
  // ****************************************
  logic [7:0]              pctl_q;
  logic [7:0]              pctl_d;
  pmrc_pkg::pmrc_mode_type mode_q;
  pmrc_pkg::pmrc_mode_type mode_d;
  logic                    pd_ext_q;
  logic                    pd_ext_d;
  logic [7:0]              wval;

  // Mode walk:
  //   run   -> idle on a write of the idle bit
  //   run   -> pdown on a write of the power-down bit (wins over idle)
  //   idle  -> run on any enabled interrupt
  //   any   -> reset on internal reset, except power-down
  //   reset -> run once the internal reset has ended
  // Power-down has no exit here at all: the oscillator is stopped, so
  // nothing would be sampled; the pin network drives sys_rst instead.
  // Writes outside run mode are ignored, since the core is halted then.
  always_comb
  begin
    pctl_d   = pctl_q;
    mode_d   = mode_q;
    pd_ext_d = pd_ext_q;
    // Reserved bit keeps its old value on writes
    wval     = (sfr_req.wdata & pmrc_pkg::PMRC_PCTL_WMASK)
               | (pctl_q & ~pmrc_pkg::PMRC_PCTL_WMASK);
    if (wr_hit && mode_q == pmrc_pkg::PMRC_RUN)
    begin
      pctl_d = wval;
      // Power-down refused while the watchdog is enabled
      if (watchdog_enable_n_pin == 1'b0)
        pctl_d[pmrc_pkg::PMRC_BIT_PDOWN] = 1'b0;
    end
    // Hardware load clears the permit; wins over a software write
    if (watchdog_counter_load)
      pctl_d[pmrc_pkg::PMRC_BIT_WLOAD] = 1'b0;

    case (mode_q)
      pmrc_pkg::PMRC_RUN:
      begin
        // Mode begins after the setting write completes
        if (pctl_d[pmrc_pkg::PMRC_BIT_PDOWN])
        begin
          mode_d   = pmrc_pkg::PMRC_PDOWN;
          pd_ext_d = ext_prog_mem;
        end
        else if (pctl_d[pmrc_pkg::PMRC_BIT_IDLE])
          mode_d = pmrc_pkg::PMRC_IDLE;
      end
      pmrc_pkg::PMRC_IDLE:
      begin
        // Enabled interrupt ends idle and clears the request bit
        if (irq_pending)
        begin
          pctl_d[pmrc_pkg::PMRC_BIT_IDLE] = 1'b0;
          mode_d = pmrc_pkg::PMRC_RUN;
        end
      end
      pmrc_pkg::PMRC_PDOWN:
        mode_d = pmrc_pkg::PMRC_PDOWN;
      pmrc_pkg::PMRC_RESET:
      begin
        pctl_d = pmrc_pkg::PMRC_PCTL_RESET;
        if (!int_rst)
          mode_d = pmrc_pkg::PMRC_RUN;
      end
      default:
        mode_d = pmrc_pkg::PMRC_RUN;
    endcase

    // Reset ends idle; power-down only the pin can end, as the
    // oscillator must restart before any sampling happens
    if (int_rst && mode_q != pmrc_pkg::PMRC_PDOWN)
    begin
      mode_d = pmrc_pkg::PMRC_RESET;
      pctl_d = pmrc_pkg::PMRC_PCTL_RESET;
    end
  end

  // Power-down exits through sys_rst, driven by the pin network
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pctl_q   <= pmrc_pkg::PMRC_PCTL_RESET;
      mode_q   <= pmrc_pkg::PMRC_RUN;
      pd_ext_q <= 1'b0;
    end
    else
    begin
      pctl_q   <= pctl_d;
      mode_q   <= mode_d;
      pd_ext_q <= pd_ext_d;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read data is held until the next read hit, so the core may take it
  // any time after the cycle that follows its read request.
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_hit)
      rdata_d = pctl_q;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign sfr_rdata = rdata_q;

  // ****************************************
  // Peripheral controls and pins
  // ****************************************
  logic in_idle;
  logic in_pd;
  logic in_rst;

  assign in_idle = (mode_q == pmrc_pkg::PMRC_IDLE);
  assign in_pd   = (mode_q == pmrc_pkg::PMRC_PDOWN);
  assign in_rst  = (mode_q == pmrc_pkg::PMRC_RESET) || int_rst;
  assign mode    = mode_q;
  assign osc_run = !in_pd;

  // Other timers, serial and interrupts get no halt; idle halts the CPU, clears capture timer and pulse output, aborts the ADC
  always_comb
  begin
    periph_ctl.cpu_halt            = in_idle || in_pd;
    periph_ctl.osc_stop            = in_pd;
    periph_ctl.capture_timer_clear = in_idle;
    periph_ctl.pulse_out_reset     = in_idle;
    periph_ctl.adc_abort           = in_idle;
    periph_ctl.baud_doubler_bit    = pctl_q[pmrc_pkg::PMRC_BIT_BAUD2];
    periph_ctl.watchdog_run        = !watchdog_enable_n_pin;
  end

  // Reset outranks every mode on the strobes: a watchdog reset may land
  // while the core is still mid-cycle, and the pins must not be left
  // to the external network. Power-down pulls both low so that no
  // external memory is selected while the supply may be lowered.

  // Strobe pins: reset and idle high, power-down low
  always_comb
  begin
    if (in_rst || in_idle)
    begin
      ale_out              = 1'b1;
      program_store_strobe = 1'b1;
    end
    else if (in_pd)
    begin
      ale_out              = 1'b0;
      program_store_strobe = 1'b0;
    end
    else
    begin
      // Quiet bit holds the address strobe low instead of toggling
      ale_out              = ale_core && !pctl_q[pmrc_pkg::PMRC_BIT_QUIET];
      program_store_strobe = program_store_strobe_core;
    end
  end

  assign port0_float          = (in_idle || in_pd) && ext_prog_mem;
  assign pulse_out_zero_force = in_idle || in_pd;
  assign port_two_restore     = in_pd && pd_ext_q;

endmodule : pmrc_ctrl

/* File: testbench/pmrc_ctrl_sva.sv */
// Port-level checker for the power-mode and reset control unit.
// Assumes it is bound onto pmrc_ctrl and sees only its ports.
`timescale 1ns/100ps
module pmrc_ctrl_sva
(
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire pmrc_pkg::pmrc_sfr_req_type    sfr_req,
  input wire logic                          irq_pending,
  input wire logic                          watchdog_enable_n_pin,
  input wire logic                          watchdog_counter_ovf,
  input wire logic                          ext_prog_mem,
  input wire logic                          rst_pin_in,
  input wire logic                          rst_pin_out,
  input wire logic                          rst_pin_oe,
  input wire logic                          core_reset,
  input wire logic                          ale_out,
  input wire logic                          program_store_strobe,
  input wire logic                          port_two_restore,
  input wire pmrc_pkg::pmrc_periph_ctl_type periph_ctl,
  input wire pmrc_pkg::pmrc_mode_type       mode
);
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic hit;
  // Write accepted only in run mode
  assign hit = sfr_req.wr && sfr_req.addr == 8'h87 && mode == pmrc_pkg::PMRC_RUN;

  // ****************************************
  // Assertions
  // ****************************************
  AST_IDLE_ENTER: assert property (hit && sfr_req.wdata[1:0] == 2'b01 |=> mode == pmrc_pkg::PMRC_IDLE)
    else $error("idle not entered after write");
  AST_IDLE_CLEAR: assert property (hit && sfr_req.wdata[1:0] == 2'b01 |=> periph_ctl.capture_timer_clear
    && periph_ctl.pulse_out_reset && periph_ctl.adc_abort)
    else $error("idle entry did not clear peripherals");
  AST_PD_BLOCK: assert property (hit && sfr_req.wdata[1] && !watchdog_enable_n_pin |=> mode != pmrc_pkg::PMRC_PDOWN)
    else $error("power-down taken with watchdog on");
  AST_PD_WINS: assert property (hit && sfr_req.wdata[1:0] == 2'b11 && watchdog_enable_n_pin
    |=> mode == pmrc_pkg::PMRC_PDOWN)
    else $error("power-down did not win");
  AST_IDLE_PINS: assert property (mode == pmrc_pkg::PMRC_IDLE |-> periph_ctl.cpu_halt && ale_out && program_store_strobe)
    else $error("idle pin state wrong");
  AST_IDLE_WDOG: assert property (mode == pmrc_pkg::PMRC_IDLE && !watchdog_enable_n_pin |-> periph_ctl.watchdog_run)
    else $error("watchdog stopped in idle");
  AST_PD_PINS: assert property (mode == pmrc_pkg::PMRC_PDOWN |-> periph_ctl.osc_stop && !ale_out && !program_store_strobe)
    else $error("power-down pin state wrong");
  AST_PD_HOLD: assert property (mode == pmrc_pkg::PMRC_PDOWN |=> mode == pmrc_pkg::PMRC_PDOWN)
    else $error("power-down left without reset");
  AST_PORT_TWO: assert property (mode == pmrc_pkg::PMRC_PDOWN && ext_prog_mem |-> port_two_restore)
    else $error("port two not restored");
  AST_IRQ_WAKE: assert property (mode == pmrc_pkg::PMRC_IDLE && irq_pending && !core_reset && !rst_pin_in
    && !watchdog_counter_ovf |=> mode == pmrc_pkg::PMRC_RUN)
    else $error("interrupt did not end idle");
  AST_RST_PINS: assert property (core_reset |-> ale_out && program_store_strobe)
    else $error("strobes low during reset");
  AST_WDOG_PULL: assert property (watchdog_counter_ovf && !watchdog_enable_n_pin |=> rst_pin_oe && rst_pin_out
    && core_reset)
    else $error("watchdog overflow did not pull reset");
endmodule : pmrc_ctrl_sva

bind pmrc_ctrl pmrc_ctrl_sva u_sva
(
  .clk, .sys_rst, .sfr_req, .irq_pending, .watchdog_enable_n_pin, .watchdog_counter_ovf, .ext_prog_mem,
  .rst_pin_in, .rst_pin_out, .rst_pin_oe, .core_reset, .ale_out, .program_store_strobe, .port_two_restore,
  .periph_ctl, .mode
);

/* File: testbench/pmrc_rst_net.sv */
// External reset network seen from the reset pin.
// Assumes a pull-down on the pin; the device pulls up only when enabled.
`timescale 1ns/100ps
module pmrc_rst_net
(
  input  wire logic ext_hold,
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  output logic      rst_pin_in
);
  // Wired-OR of source and pull-up; released pin falls to the pull-down level
  assign rst_pin_in = ext_hold | (rst_pin_oe & rst_pin_out);
endmodule : pmrc_rst_net

/* File: testbench/pmrc_ctrl_bench.sv */
// Self-checking bench for the power-mode and reset control unit.
// Assumes inputs change at the falling edge; reset network is modelled apart.
`timescale 1ns/100ps
module pmrc_ctrl_bench;
  logic clk = 0, sys_rst = 1, irq = 0, ewn = 1, wload = 0, wovf = 0, extm = 0, hold = 0, ale_c = 0;
  logic rpin, rout, roe, crst, ale_o, pss, p2r, p0f, pzf;
  logic seen = 0;
  logic [7:0] rdata;
  pmrc_pkg::pmrc_sfr_req_type req = '0;
  pmrc_pkg::pmrc_periph_ctl_type pctl;
  pmrc_pkg::pmrc_mode_type mode;
  int n_errors = 0, num_checks = 0, cyc = 0, cnt;

  // Clock and hang guard; the whole run needs well under a thousand cycles
  initial forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      finish_test();
    end
  end
  // Sticky view of core reset; posedge keeps it clear of the negedge clears
  always @(posedge clk) seen <= seen | crst;

  pmrc_rst_net u_net (.ext_hold(hold), .rst_pin_out(rout), .rst_pin_oe(roe), .rst_pin_in(rpin));
  pmrc_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(rdata), .irq_pending(irq),
    .watchdog_enable_n_pin(ewn), .watchdog_counter_load(wload), .watchdog_counter_ovf(wovf),
    .ext_prog_mem(extm), .rst_pin_in(rpin), .rst_pin_out(rout), .rst_pin_oe(roe), .core_reset(crst),
    .ale_core(ale_c), .program_store_strobe_core(ale_c), .ale_out(ale_o), .program_store_strobe(pss),
    .port_two_restore(p2r), .port0_float(p0f), .pulse_out_zero_force(pzf), .periph_ctl(pctl), .mode(mode));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] e);
    @(negedge clk);
    req = '{1'b0, 1'b1, 8'h87, 8'h00};
    @(negedge clk);
    req = '0;
    chk(nm, e, rdata);
  endtask : rd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd("reset", 8'h00);
    wr(8'h87, 8'hfc);
    rd("rsvd", 8'hbc);
    chk("baud", 1, pctl.baud_doubler_bit);
    ale_c = 1;
    @(negedge clk);
    chk("quiet", 0, ale_o);
    ale_c = 0;
    @(negedge clk);
    wr(8'h86, 8'h00);
    rd("addr", 8'hbc);
    wload = 1;
    @(negedge clk);
    wload = 0;
    rd("wle", 8'hac);
    wr(8'h87, 8'h00);
  endtask : t_regs
  task automatic t_idle();
    wr(8'h87, 8'h0d);
    chk("idle", pmrc_pkg::PMRC_IDLE, mode);
    chk("pwm0hi", 1, pzf);
    chk("p0drv", 0, p0f);
    irq = 1;
    @(negedge clk);
    irq = 0;
    @(negedge clk);
    chk("wake", pmrc_pkg::PMRC_RUN, mode);
    rd("flags", 8'h0c);
    ale_c = 1;
    @(negedge clk);
    chk("alerun", 1, ale_o);
    ale_c = 0;
  endtask : t_idle
  task automatic t_pd();
    ewn = 0;
    wr(8'h87, 8'h02);
    chk("pdblk", pmrc_pkg::PMRC_RUN, mode);
    rd("pdbit", 8'h00);
    ewn = 1;
    extm = 1;
    wr(8'h87, 8'ha3);
    chk("pd", pmrc_pkg::PMRC_PDOWN, mode);
    chk("p2", 1, p2r);
    chk("p0flt", 1, p0f);
    irq = 1;
    repeat (4) @(negedge clk);
    chk("pdhold", pmrc_pkg::PMRC_PDOWN, mode);
    irq = 0;
    sys_rst = 1;
    @(negedge clk);
    sys_rst = 0;
    rd("pdexit", 8'h00);
  endtask : t_pd
  task automatic t_pin();
    seen = 0;
    hold = 1;
    repeat (10) @(negedge clk);
    hold = 0;
    repeat (2) @(negedge clk);
    chk("short", 0, seen);
    wr(8'h87, 8'h01);
    seen = 0;
    hold = 1;
    repeat (40) @(negedge clk);
    hold = 0;
    repeat (30) @(negedge clk);
    chk("long", 1, seen);
    chk("pinexit", pmrc_pkg::PMRC_RUN, mode);
    rd("pinreg", 8'h00);
  endtask : t_pin
  task automatic t_wdog();
    ewn = 0;
    wovf = 1;
    @(negedge clk);
    wovf = 0;
    cnt = 0;
    repeat (60) @(negedge clk) cnt += int'(roe === 1'b1);
    chk("pulse", 1, 8'(cnt > 24 && cnt <= 36));
    ewn = 1;
    repeat (30) @(negedge clk);
    chk("wdexit", pmrc_pkg::PMRC_RUN, mode);
  endtask : t_wdog

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    sys_rst = 0;
    t_regs();
    t_idle();
    t_pd();
    t_pin();
    t_wdog();
    finish_test();
  end
endmodule : pmrc_ctrl_bench
